// File: rstc_map.svh
// Register offsets, field positions, reset values and timing counts of the reset controller
`ifndef RSTC_MAP_SVH
`define RSTC_MAP_SVH

// Register indices; byte address is four times the index
`define RSTC_IDX_FLAGS 8'h00
`define RSTC_IDX_SOFTWARE_RESET_REQUEST 8'h01

// Cause flag bit positions
`define RSTC_BIT_POR 0
`define RSTC_BIT_BOD 1
`define RSTC_BIT_EXT 2
`define RSTC_BIT_WDT 3
`define RSTC_BIT_SW 4
`define RSTC_BIT_DBG 5

// Software reset trigger bit in the request register
`define RSTC_BIT_SWTRIG 0

// Flag value right after a power-on reset
`define RSTC_FLAGS_POR 6'h01

// Unlock window length in CPU instructions
`define RSTC_CCP_WINDOW 3'h4

// Start-up time unit in microseconds, and the clock rate in MHz
`define RSTC_SUT_UNIT_US 1000
`define RSTC_CLK_MHZ 10
`define RSTC_SUT_STEP_CYC (`RSTC_SUT_UNIT_US * `RSTC_CLK_MHZ)

// Memory scan source code that means no scan at start-up
`define RSTC_CRC_NONE 2'h0

`endif

// File: rstc_pkg.sv
// Types of the reset controller
package rstc_pkg;

	// Reset sequence phases
	typedef enum logic [2:0]
	{
		RSTC_RUN,
		RSTC_HOLD,
		RSTC_FUSE,
		RSTC_SUT,
		RSTC_CRC
	} rstc_state_type;

	// Whole state of the controller
	typedef struct packed
	{
		rstc_state_type state;
		logic [5:0]     flags;
		logic           power;
		logic           por_boot;
		logic           sw_pend;
		logic           wdt_pend;
		logic [2:0]     win;
		logic [23:0]    cnt;
		logic           wr_flags;
		logic           wr_software_reset_request;
		logic [7:0]     rd;
	} rstc_regs_type;

endpackage

// File: rstc_reset_controller.sv
// Reset controller: source gathering, two-phase reset sequence, cause flags, AHB-Lite slave
`timescale 1ns/1ps
`include "rstc_map.svh"

// Function
// R1 - Controller always on; some sources fuse-enabled
// R2 - Every reset reloads fuse-loaded registers
// R3 - Record reset cause in flag register
// R4 - Power-on holds reset through whole init
// R5 - Power-on reasserts reset with no delay
// R6 - Brown-out resets; unused level forced minimum
// R7 - Enabled pin holds reset while low
// R8 - Watchdog time-out issues a reset
// R9 - Software trigger write starts full reset
// R10 - Debug reset only from external debugger
// R11 - Only power resets reset debug logic
// R12 - Hold while sources active, then init
// R13 - Start-up delay only after power resets
// R14 - Init lengthened by start-up memory scan
// R15 - Works in active and every sleep mode
// R16 - Software writes key, then register quickly
// R17 - Protected write without unlock is ignored
// R18 - Cause flag cleared by writing one
// R19 - Power-on clears all flags but power-on
// R20 - Flag bits: 5 debug down to 0 power-on
// R21 - After power-on only its flag until boot
// R22 - Software trigger bit always reads zero
// R23 - Internal reset released on a clock edge
module rstc_reset_controller
#(
	parameter int          SUT_STEP_CYC = `RSTC_SUT_STEP_CYC, // Cycles per start-up step
	parameter logic [7:0]  IO_KEY       = 8'h5A               // Unlock key, value arbitrary
)
(
	input  wire logic        sys_clk_i,
	input  wire logic        rst_n_i,
	// Reset sources
	input  wire logic        por_req_i,
	input  wire logic        bod_req_i,
	input  wire logic        bod_fuse_en_i,
	input  wire logic        chip_erase_i,
	input  wire logic        ext_reset_n_i,
	input  wire logic        reset_pin_config_i,
	input  wire logic        wdt_req_i,
	input  wire logic        dbg_reset_req_i,
	// Fuse settings and init helpers
	input  wire logic [2:0]  startup_time_setting_i,
	input  wire logic [1:0]  crc_source_select_i,
	input  wire logic        fuse_done_i,
	input  wire logic        crc_done_i,
	// Unlock key path from the CPU
	input  wire logic        ccp_key_wr_i,
	input  wire logic [7:0]  ccp_key_i,
	input  wire logic        cpu_insn_i,
	// AHB-Lite slave
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic      [31:0] hrdata_o,
	output logic             hreadyout_o,
	output logic             hresp_o,
	// Reset outputs
	output logic             sys_reset_n_o,
	output logic             dbg_reset_n_o,
	output logic             fuse_reload_o,
	output logic             crc_start_o,
	output logic             bod_force_min_o
);

	////////////////////////////////////////////////////////////////////////////
	// Declarations

	rstc_pkg::rstc_regs_type r_q;   // Registered state
	rstc_pkg::rstc_regs_type r_d;   // Next state
	logic [5:0]  src;               // Active sources in flag order
	logic        any_src;           // Any source requests reset
	logic        bod_act;           // Brown-out request, gated
	logic        ext_act;           // Pin request, gated
	logic        addr_ph;           // Valid address phase
	logic [7:0]  idx;               // Register index of the address
	logic [5:0]  clr;               // Flags cleared by software
	logic [5:0]  set;               // Flags set by hardware
	logic        crc_on;            // Start-up scan configured
	logic [23:0] sut_cyc;           // Start-up wait in cycles

	////////////////////////////////////////////////////////////////////////////
	// Source gathering

	// Brown-out always counts once its fuse enables it; the pin only when configured
	assign bod_act = bod_req_i && bod_fuse_en_i;                  // [R1] [R6]
	assign ext_act = reset_pin_config_i && !ext_reset_n_i;        // [R1] [R7]

	// Flag-ordered vector; debug request only comes from the debugger port
	always_comb
	begin
		src = 6'h00;
		src[`RSTC_BIT_POR] = por_req_i;                           // [R4]
		src[`RSTC_BIT_BOD] = bod_act;                             // [R6]
		src[`RSTC_BIT_EXT] = ext_act;                             // [R7]
		src[`RSTC_BIT_WDT] = r_q.wdt_pend;                        // [R8]
		src[`RSTC_BIT_SW]  = r_q.sw_pend;                         // [R9]
		src[`RSTC_BIT_DBG] = dbg_reset_req_i;                     // [R10]
	end

	assign any_src = |src;
	assign crc_on  = crc_source_select_i != `RSTC_CRC_NONE;
	assign sut_cyc = 24'(int'(startup_time_setting_i) * SUT_STEP_CYC);

	////////////////////////////////////////////////////////////////////////////
	// Bus decode

	// Only NONSEQ/SEQ transfers count; IDLE and BUSY are ignored
	assign addr_ph = hsel_i && htrans_i[1] && hready_i;
	assign idx     = haddr_i[9:2];

	// Write-one clears on the flag register during its data phase
	assign clr = r_q.wr_flags ? hwdata_i[5:0] : 6'h00;            // [R18]

	// Hardware sets flags for all active sources, but only the power-on flag while not yet booted after power-on
	always_comb
	begin
		set = 6'h00;
		if (r_q.por_boot)
		begin
			set[`RSTC_BIT_POR] = por_req_i;                       // [R21]
		end
		else
		begin
			set = src;                                            // [R3] [R20]
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic

	// One process computes the whole next state
	always_comb
	begin
		r_d = r_q;
		r_d.wr_flags = 1'b0;
		r_d.wr_software_reset_request  = 1'b0;

		// Set wins over a same-cycle software clear
		r_d.flags = (r_q.flags & ~clr) | set;                     // [R18]

		// Supply below threshold behaves like the power-on reset
		if (por_req_i)
		begin
			r_d.flags    = `RSTC_FLAGS_POR;                       // [R19] [R21]
			r_d.por_boot = 1'b1;
		end

		// Remember whether a supply source was part of this reset
		if (por_req_i || bod_act)
		begin
			r_d.power = 1'b1;                                     // [R13]
		end

		// Watchdog time-out pulse is held until the hold phase sees it
		if (wdt_req_i)
		begin
			r_d.wdt_pend = 1'b1;                                  // [R8]
		end

		// Unlock window opens on the key, then runs down per instruction
		if (ccp_key_wr_i && ccp_key_i == IO_KEY)
		begin
			r_d.win = `RSTC_CCP_WINDOW;                           // [R16]
		end
		else if (cpu_insn_i && r_q.win != 3'h0)
		begin
			r_d.win = r_q.win - 3'h1;
		end

		// Protected write only takes effect inside the window
		if (r_q.wr_software_reset_request && r_q.win != 3'h0)
		begin
			r_d.win = 3'h0;
			if (hwdata_i[`RSTC_BIT_SWTRIG])
			begin
				r_d.sw_pend = 1'b1;                               // [R9] [R17]
			end
		end

		// Address phase: latch write target and prepare read data
		if (addr_ph)
		begin
			r_d.wr_flags = hwrite_i && idx == `RSTC_IDX_FLAGS;
			r_d.wr_software_reset_request  = hwrite_i && idx == `RSTC_IDX_SOFTWARE_RESET_REQUEST;
			// Trigger register and unmapped words read as zero
			r_d.rd = 8'h00;                                       // [R22]
			if (!hwrite_i && idx == `RSTC_IDX_FLAGS)
			begin
				r_d.rd = {2'b00, r_q.flags};                      // [R3]
			end
		end

		// Reset sequence
		case (r_q.state)
			// Normal operation
			rstc_pkg::RSTC_RUN:
			begin
				if (any_src)
				begin
					r_d.state = rstc_pkg::RSTC_HOLD;              // [R12]
				end
			end
			// First phase: stay while any source is active
			rstc_pkg::RSTC_HOLD:
			begin
				// Single-shot sources have been recorded, so drop them
				r_d.sw_pend  = 1'b0;
				r_d.wdt_pend = 1'b0;
				if (!any_src)
				begin
					r_d.state = rstc_pkg::RSTC_FUSE;              // [R12]
				end
			end
			// Second phase: reload fuse-loaded registers
			rstc_pkg::RSTC_FUSE:
			begin
				if (fuse_done_i)
				begin
					if (r_q.power)
					begin
						r_d.state = rstc_pkg::RSTC_SUT;           // [R13]
						r_d.cnt   = sut_cyc;
					end
					else if (crc_on)
					begin
						r_d.state = rstc_pkg::RSTC_CRC;           // [R14]
					end
					else
					begin
						r_d.state = rstc_pkg::RSTC_RUN;           // [R2]
					end
				end
			end
			// Start-up delay after supply resets only
			rstc_pkg::RSTC_SUT:
			begin
				if (r_q.cnt != 24'h000000)
				begin
					r_d.cnt = r_q.cnt - 24'h000001;               // [R13]
				end
				else if (crc_on)
				begin
					r_d.state = rstc_pkg::RSTC_CRC;               // [R14]
				end
				else
				begin
					r_d.state = rstc_pkg::RSTC_RUN;               // [R4]
				end
			end
			// Memory scan stretches the init phase
			rstc_pkg::RSTC_CRC:
			begin
				if (crc_done_i)
				begin
					r_d.state = rstc_pkg::RSTC_RUN;               // [R14]
				end
			end
			// Unused encodings recover through a full sequence
			default:
			begin
				r_d.state = rstc_pkg::RSTC_HOLD;
			end
		endcase

		// Boot finished: clear supply marker and power-on lockout
		if (r_q.state != rstc_pkg::RSTC_RUN && r_d.state == rstc_pkg::RSTC_RUN)
		begin
			r_d.power    = 1'b0;
			r_d.por_boot = 1'b0;                                  // [R21]
		end

		// A new source restarts the sequence from any phase
		if (any_src && r_q.state != rstc_pkg::RSTC_RUN)
		begin
			r_d.state = rstc_pkg::RSTC_HOLD;                      // [R12]
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State register

	// The power-on reset seeds the flags; nothing here depends on sleep state
	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			r_q          <= '0;
			r_q.state    <= rstc_pkg::RSTC_HOLD;                  // [R4] [R15]
			r_q.flags    <= `RSTC_FLAGS_POR;                      // [R19]
			r_q.power    <= 1'b1;
			r_q.por_boot <= 1'b1;
		end
		else
		begin
			r_q <= r_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	// Zero-wait slave, always OKAY
	assign hreadyout_o = 1'b1;
	assign hresp_o     = 1'b0;
	assign hrdata_o    = {24'h000000, r_q.rd};

	// Release only from the registered RUN phase; supply drop cuts in at once
	assign sys_reset_n_o = rst_n_i && !por_req_i && !bod_act
		&& r_q.state == rstc_pkg::RSTC_RUN;                       // [R5] [R23] [R11]

	// Debug logic sees supply resets only
	assign dbg_reset_n_o = rst_n_i && !por_req_i && !bod_act
		&& !(r_q.power && r_q.state == rstc_pkg::RSTC_HOLD);      // [R11]

	assign fuse_reload_o = r_q.state == rstc_pkg::RSTC_FUSE;      // [R2]
	assign crc_start_o   = r_q.state == rstc_pkg::RSTC_CRC;       // [R14]

	// Unused detector is pinned low while inside reset or erasing
	assign bod_force_min_o = !bod_fuse_en_i
		&& (chip_erase_i || r_q.state != rstc_pkg::RSTC_RUN);     // [R6]

	////////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	AST_POR_NO_DELAY: assert property (por_req_i |-> !sys_reset_n_o) // [R5]
		else $error("power-on request did not hold reset");

	AST_PIN_HOLDS: assert property
		(reset_pin_config_i && !ext_reset_n_i |=> !sys_reset_n_o) // [R7]
		else $error("pin low did not hold reset");

	AST_WDT_RESETS: assert property (wdt_req_i |=> ##1 !sys_reset_n_o) // [R8]
		else $error("watchdog did not reset");

	AST_SOURCE_TO_HOLD: assert property
		(any_src |=> r_q.state == rstc_pkg::RSTC_HOLD)            // [R12]
		else $error("active source did not enter hold");

	AST_SUT_POWER_ONLY: assert property
		(r_q.state == rstc_pkg::RSTC_SUT |-> r_q.power)           // [R13]
		else $error("start-up delay without supply reset");

	AST_POR_FLAGS: assert property (por_req_i |=> r_q.flags == 6'h01) // [R19]
		else $error("power-on left other flags");

	AST_SOFTWARE_RESET_TRIGGER_READ_ZERO: assert property
		(addr_ph && !hwrite_i && idx == `RSTC_IDX_SOFTWARE_RESET_REQUEST |=> hrdata_o == 32'h00000000) // [R22]
		else $error("trigger register read non-zero");

	AST_LOCKED_WRITE: assert property
		(r_q.wr_software_reset_request && r_q.win == 3'h0 && !r_q.sw_pend |=> !r_q.sw_pend) // [R17]
		else $error("locked write started reset");

	AST_DBG_POWER_ONLY: assert property
		(!dbg_reset_n_o |-> por_req_i || bod_act || r_q.power)    // [R11]
		else $error("debug reset from user source");

	AST_W1C: assert property
		(r_q.wr_flags && hwdata_i[`RSTC_BIT_EXT] && !ext_act
			|=> !r_q.flags[`RSTC_BIT_EXT])                        // [R18]
		else $error("write one did not clear flag");

endmodule

// File: rstc_boot_partner.sv
// Fuse loader and memory scanner model that answers the controller's init requests
`timescale 1ns/1ps

////////////////////
module rstc_boot_partner
(
	input  wire logic       sys_clk_i,
	input  wire logic       fuse_reload_i,
	input  wire logic       crc_start_i,
	input  wire logic [3:0] lag_i,
	output logic            fuse_done_o,
	output logic            crc_done_o
);
	logic [3:0] wait_q; // Cycles the current request has stood

	// Count while a request stands; restart after each answer so the scan waits too
	always_ff @(posedge sys_clk_i)
	begin
		if (fuse_done_o || crc_done_o)
			wait_q <= 4'h0;
		else if (fuse_reload_i || crc_start_i)
			wait_q <= wait_q + 4'h1;
		else
			wait_q <= 4'h0;
	end

	// Done only while its own request is up, so a stale answer never leaks
	assign fuse_done_o = fuse_reload_i && (wait_q >= lag_i);
	assign crc_done_o  = crc_start_i && (wait_q >= lag_i);
endmodule

// File: test_reset_controller.sv
// Self-checking testbench of the reset controller through its register bus
`timescale 1ns/1ps

////////////////////
module test_reset_controller;
	localparam int          STARTUP_TIME_SETTING = 4;            // Shortened start-up step
	localparam logic [7:0]  KEY = 8'h5A;        // Unlock key, value arbitrary
	localparam logic [31:0] FLG = 32'h00000000; // Cause flag address
	localparam logic [31:0] TRG = 32'h00000004; // Trigger register address
	logic        sys_clk_i = 1'b0, rst_n_i = 1'b0;                // Clock and reset
	logic        por_req_i = 1'b0, bod_req_i = 1'b0;              // Supply sources
	logic        bod_fuse_en_i = 1'b0, chip_erase_i = 1'b0;       // Brown-out fuse, erase
	logic        ext_reset_n_i = 1'b1, reset_pin_config_i = 1'b0; // Pin and its fuse
	logic        wdt_req_i = 1'b0, dbg_reset_req_i = 1'b0;        // User sources
	logic [2:0]  startup_time_setting_i = 3'h3;                   // Start-up steps
	logic [1:0]  crc_source_select_i = 2'h0;                      // No scan at first
	logic        ccp_key_wr_i = 1'b0, cpu_insn_i = 1'b0;          // Unlock path
	logic [7:0]  ccp_key_i = KEY;                                 // Key value
	logic        hsel_i = 1'b0, hwrite_i = 1'b0;                  // Bus select, direction
	logic [1:0]  htrans_i = 2'h0;                                 // Transfer kind
	logic [2:0]  hsize_i = 3'h2;                                  // Whole words only
	logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0;               // Address and data
	logic [3:0]  lag = 4'h2;                                      // Init answer delay
	logic        hready_i, fuse_done_i, crc_done_i;               // Bus ready, init answers
	logic [31:0] hrdata_o;
	logic        hreadyout_o, hresp_o, sys_reset_n_o, dbg_reset_n_o;
	logic        fuse_reload_o, crc_start_o, bod_force_min_o;
	int          miscompares = 0, checks_done = 0, t_pin, t_por; // Counters, boot lengths
	int          kinds [5] = '{2, 3, 4, 5, 1};                   // Pin, dog, soft, debug, brown
	logic        u_dut_sf_dummy, u_dut_sc_dummy;                 // Unused phase notes of first boot

	// The single slave's ready is the bus ready
	assign hready_i = hreadyout_o;

	rstc_reset_controller #(.SUT_STEP_CYC(STARTUP_TIME_SETTING), .IO_KEY(KEY)) u_dut
	(
		.sys_clk_i, .rst_n_i, .por_req_i, .bod_req_i, .bod_fuse_en_i, .chip_erase_i,
		.ext_reset_n_i, .reset_pin_config_i, .wdt_req_i, .dbg_reset_req_i,
		.startup_time_setting_i, .crc_source_select_i, .fuse_done_i, .crc_done_i,
		.ccp_key_wr_i, .ccp_key_i, .cpu_insn_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
		.hsize_i, .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .sys_reset_n_o,
		.dbg_reset_n_o, .fuse_reload_o, .crc_start_o, .bod_force_min_o
	);

	rstc_boot_partner u_boot
	(
		.sys_clk_i, .fuse_reload_i(fuse_reload_o), .crc_start_i(crc_start_o), .lag_i(lag),
		.fuse_done_o(fuse_done_i), .crc_done_o(crc_done_i)
	);

	////////////////////
	// Verdict and the end of the run, shared by the tests and the watchdog
	task automatic report_and_stop();
		if (miscompares == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Byte comparison; case inequality so an unknown never matches
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Single-bit comparison
	task automatic cmp1(input logic got, input logic exp);
		cmp8({7'h00, got}, {7'h00, exp});
	endtask

	// One single AHB-Lite transfer; waits on ready in both phases
	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd,
		output logic [31:0] rdat);
		@(posedge sys_clk_i);
		hsel_i <= 1'b1;
		haddr_i <= a;
		htrans_i <= 2'h2;
		hwrite_i <= w;
		do @(posedge sys_clk_i); while (hready_i !== 1'b1);
		htrans_i <= 2'h0;
		hsel_i <= 1'b0;
		hwdata_i <= wd;
		do @(posedge sys_clk_i); while (hready_i !== 1'b1);
		rdat = hrdata_o;
		cmp1(hresp_o, 1'b0);
	endtask

	// Register write
	task automatic wr(input logic [31:0] a, input logic [31:0] wd);
		logic [31:0] dummy;
		ahb(1'b1, a, wd, dummy);
	endtask

	// Register read against an expected byte
	task automatic rd(input logic [31:0] a, input logic [7:0] e);
		logic [31:0] d;
		ahb(1'b0, a, 32'h0, d);
		cmp8(d[7:0], e);
	endtask

	// Unlock key written by the CPU
	task automatic key();
		@(posedge sys_clk_i);
		ccp_key_wr_i <= 1'b1;
		@(posedge sys_clk_i);
		ccp_key_wr_i <= 1'b0;
	endtask

	// Reset must stay released; a glitch of one cycle is caught
	task automatic quiet();
		logic bad;
		bad = 1'b0;
		repeat (10)
		begin
			@(posedge sys_clk_i);
			#1;
			bad = bad | (sys_reset_n_o !== 1'b1);
		end
		// Back on an edge so the caller's next stimulus lands on it
		@(posedge sys_clk_i);
		cmp1(bad, 1'b0);
	endtask

	// Bounded wait for release; notes which init phases were seen
	task automatic wait_boot(output int cyc, output logic sf, output logic sc);
		cyc = 0;
		sf = 1'b0;
		sc = 1'b0;
		while (sys_reset_n_o !== 1'b1 && cyc < 2000)
		begin
			@(posedge sys_clk_i);
			#1;
			cyc++;
			sf = sf | (fuse_reload_o === 1'b1);
			sc = sc | (crc_start_o === 1'b1);
		end
		// A boot that never ends is a failure, not a silent return
		if (cyc >= 2000)
		begin
			miscompares++;
			report_and_stop();
		end
	endtask

	// Drive one level source; the pin is active low
	task automatic drive(input int kind, input logic on);
		case (kind)
			0: por_req_i <= on;
			1: bod_req_i <= on;
			2: ext_reset_n_i <= ~on;
			3: wdt_req_i <= on;
			5: dbg_reset_req_i <= on;
			default: ;
		endcase
	endtask

	// One reset from a source, then its boot, flag and optional clear
	task automatic user_reset(input int kind, input logic clr, output int cyc);
		logic sf;
		logic sc;
		@(posedge sys_clk_i);
		if (kind == 4)
		begin
			key();
			wr(TRG, 32'h00000001);
		end
		else
			drive(kind, 1'b1);
		#1;
		if (kind == 0)
			cmp1(sys_reset_n_o, 1'b0);
		@(posedge sys_clk_i);
		if (kind == 3)
			wdt_req_i <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
		#1;
		cmp1(sys_reset_n_o, 1'b0);
		cmp1(dbg_reset_n_o, kind > 1);
		@(posedge sys_clk_i);
		drive(kind, 1'b0);
		wait_boot(cyc, sf, sc);
		cmp1(sf, 1'b1);
		cmp1(sc, crc_source_select_i != 2'h0);
		rd(FLG, 8'h01 << kind);
		if (clr)
			wr(FLG, 32'h0000003F);
	endtask

	////////////////////
	// Free-running clock at 10 MHz
	initial
	begin
		forever #50 sys_clk_i = ~sys_clk_i;
	end

	// Watchdog at 20000 cycles, well past the expected run length of a few hundred cycles
	initial
	begin
		#(100 * 20000);
		miscompares++;
		report_and_stop();
	end

	// Main sequence
	initial
	begin
		repeat (8) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		rd(FLG, 8'h01);
		wait_boot(t_por, u_dut_sf_dummy, u_dut_sc_dummy);
		cmp1(t_por >= 3 * STARTUP_TIME_SETTING, 1'b1);
		rd(TRG, 8'h00);
		rd(32'h00000008, 8'h00);
		wr(FLG, 32'h00000001);
		rd(FLG, 8'h00);
		ext_reset_n_i <= 1'b0;
		quiet();
		ext_reset_n_i <= 1'b1;
		bod_req_i <= 1'b1;
		chip_erase_i <= 1'b1;
		quiet();
		cmp1(bod_force_min_o, 1'b1);
		bod_req_i <= 1'b0;
		bod_fuse_en_i <= 1'b1;
		@(posedge sys_clk_i);
		#1;
		cmp1(bod_force_min_o, 1'b0);
		@(posedge sys_clk_i);
		chip_erase_i <= 1'b0;
		wr(TRG, 32'h00000001);
		quiet();
		key();
		repeat (16) @(posedge sys_clk_i) cpu_insn_i <= ~cpu_insn_i;
		wr(TRG, 32'h00000001);
		quiet();
		rd(FLG, 8'h00);
		reset_pin_config_i <= 1'b1;
		foreach (kinds[i]) user_reset(kinds[i], 1'b1, t_pin);
		lag <= 4'h9;
		crc_source_select_i <= 2'h1;
		user_reset(2, 1'b0, t_pin);
		user_reset(0, 1'b1, t_por);
		cmp1(t_por - t_pin >= 3 * STARTUP_TIME_SETTING, 1'b1);
		report_and_stop();
	end

endmodule
